// ### bb_model.sv
// Baseband controller model: transmit bit stream and demodulated receive bits.
// Assumes the sequencer samples both on the rising clock edge.
`timescale 1ns/1ps
module bb_model (
  // Clock, reset and bench control
  input wire clk_in,
  input wire rst_in,
  input wire send_in,
  input wire [19:0] pattern_in,
  output reg [4:0] sent_out,
  // Lines into the sequencer
  output reg tx_data_valid_out,
  output reg tx_data_out,
  input wire tx_data_ready_in,
  output reg rx_demod_bit_out
);
  reg took;
  reg [4:0] k;
  // A bit counts as taken only at the rising edge that saw ready high.
  always @(posedge clk_in)
    took <= tx_data_valid_out && tx_data_ready_in;
  // Lines change off the sampling edge; an idle data line toggles so it never looks held.
  always @(negedge clk_in)
  begin
    k = rst_in ? 5'h00 : sent_out + {4'h0, took};
    sent_out <= k;
    tx_data_valid_out <= send_in && k < 5'd20;
    tx_data_out <= rst_in ? 1'b0 : (send_in && k < 5'd20) ? pattern_in[5'd19 - k] : ~tx_data_out;
    rx_demod_bit_out <= rst_in ? 1'b0 : ~rx_demod_bit_out ^ k[1];
  end
endmodule

// ### fsk_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module fsk_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 16,
  parameter AW = 4
)
(
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Fill side
  input wire in_valid_in,
  input wire [WIDTH-1:0] in_data_in,
  output wire in_ready_out,
  // Drain side
  output wire out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input wire out_ready_in
);
  // ==========================================================================
  // Storage and pointers
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_out = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // Pointer and count update; push and pop may share a cycle.
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop & ~push)
      begin
        count <= count - 1'b1;
      end
    end
  end

  // Data array needs no reset.
  always @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule

// ### fsk_radio_mode_sequencer.v
// Mode and calibration sequencer of a low-IF FSK transceiver, with its transmit data path.
// Assumes all inputs synchronous to clk_in; the reference input arrives as a one-cycle tick.
`timescale 1ns/1ps
`include "fsk_seq_defines.vh"

module fsk_radio_mode_sequencer #(
  parameter TX_CALIBRATE_PHASE_CYCLES = `TX_CALIBRATE_PHASE_CYC,
  parameter FULLCAL_CYCLES = `FULLCAL_CYC,
  parameter RX_CALIBRATE_PHASE_CYCLES = `RX_CALIBRATE_PHASE_CYC,
  parameter CNT_W = 16,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
)
(
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Parallel mode lines
  input wire chip_active_line_in,
  input wire receive_select_line_in,
  input wire ref_tick_in,
  // Transmit data stream
  input wire tx_data_valid_in,
  input wire tx_data_in,
  output reg tx_data_ready_out,
  // Receive data from demodulator and sliced output
  input wire rx_demod_bit_in,
  output reg rx_sliced_data_out,
  // Serial configuration bus
  input wire ser_clk_in,
  input wire ser_data_in,
  input wire ser_load_n_in,
  output reg [`CFG_DATA_W-1:0] cfg_reg0_out,
  output reg [`CFG_DATA_W-1:0] cfg_reg1_out,
  output reg [`CFG_DATA_W-1:0] cfg_reg2_out,
  // Analog chain controls
  output reg rx_chain_on_out,
  output reg tx_chain_on_out,
  output reg tx_rf_output_en_out,
  output reg synth_loop_close_out,
  output reg charge_pump_en_out,
  output reg mod_enable_out,
  output reg [1:0] mod_drive_out,
  output reg lo_shift_out,
  output reg [`TUNE_W-1:0] filter_tune_out,
  output reg calibrating_out,
  output reg [4:0] mode_out
);
  // ==========================================================================
  // States, one-hot
  // Six states, one bit each; mode_out folds the two transmit states onto one bit.
  reg [5:0] state;
  reg [5:0] next_state;
  localparam S_STANDBY = 6'h01;
  localparam S_FULLCAL = 6'h02;
  localparam S_RX_CALIBRATE_PHASE = 6'h04;
  localparam S_RX = 6'h08;
  localparam S_TX_CALIBRATE_PHASE = 6'h10;
  localparam S_TX = 6'h20;

  reg [CNT_W-1:0] cal_cnt;
  reg [CNT_W-1:0] next_cal_cnt;
  reg chip_prev;
  reg rxsel_prev;
  reg [`TUNE_W-1:0] tune;
  wire fifo_out_valid;
  wire fifo_out_data;
  wire fifo_pop;
  wire fifo_in_ready;
  wire fifo_push;
  wire fifo_taken;
  reg [FIFO_AW:0] fill;
  wire [FIFO_AW:0] next_fill;
  wire chip_rise;
  wire rxsel_fall;

  assign chip_rise = chip_active_line_in & ~chip_prev;
  assign rxsel_fall = ~receive_select_line_in & rxsel_prev;

  // ==========================================================================
  // Transmit data buffer: drained only while modulating; it fills in every state but transmit calibration.
  // The head is popped on the edge that registers it as a symbol, so each bit gives one symbol.
  assign fifo_pop = (next_state == S_TX);
  assign fifo_taken = fifo_pop & fifo_out_valid;
  // no data taken in transmit calibration
  // A bit is accepted only while the registered ready stands, so the sender sees exactly what was stored.
  assign fifo_push = tx_data_valid_in & tx_data_ready_out & fifo_in_ready;
  // Occupancy one edge ahead, so ready can be a flip-flop and still fall before the buffer overflows.
  assign next_fill = fill + {{FIFO_AW{1'b0}}, fifo_push} - {{FIFO_AW{1'b0}}, fifo_taken};
  fsk_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_tx_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(fifo_push),
    .in_data_in(tx_data_in),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(fifo_pop)
  );

  // Mirror of the buffer occupancy, kept here because the buffer shows only full and empty.
  // It moves with exactly the same push and pop, so the two can never drift apart.
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      fill <= {(FIFO_AW+1){1'b0}};
    end
    else
    begin
      fill <= next_fill;
    end
  end

  // ==========================================================================
  // Next-state logic.
  always @*
  begin
    next_state = state;
    next_cal_cnt = cal_cnt;
    case (state)
      S_STANDBY:
      begin
        if (chip_rise)
        begin
          next_state = S_FULLCAL;
          next_cal_cnt = {CNT_W{1'b0}};
        end
      end
      S_FULLCAL, S_RX_CALIBRATE_PHASE, S_TX_CALIBRATE_PHASE:
      begin
        if (ref_tick_in)
        begin
          next_cal_cnt = cal_cnt + 1'b1;
        end
        // Leave on the tick that completes the count, so a phase lasts exactly its tick count.
        if ((state == S_FULLCAL) && (next_cal_cnt >= FULLCAL_CYCLES[CNT_W-1:0]))
        begin
          next_state = receive_select_line_in ? S_RX : S_TX_CALIBRATE_PHASE;
          next_cal_cnt = {CNT_W{1'b0}};
        end
        // receive filter tuning ends into receive
        else if ((state == S_RX_CALIBRATE_PHASE) && (next_cal_cnt >= RX_CALIBRATE_PHASE_CYCLES[CNT_W-1:0]))
        begin
          next_state = S_RX;
        end
        else if ((state == S_TX_CALIBRATE_PHASE) && (next_cal_cnt >= TX_CALIBRATE_PHASE_CYCLES[CNT_W-1:0]))
        begin
          next_state = S_TX;
        end
      end
      S_RX:
      begin
        if (rxsel_fall)
        begin
          next_state = S_TX_CALIBRATE_PHASE;
          next_cal_cnt = {CNT_W{1'b0}};
        end
      end
      S_TX:
      begin
        if (receive_select_line_in)
        begin
          next_state = S_RX_CALIBRATE_PHASE;
          next_cal_cnt = {CNT_W{1'b0}};
        end
      end
      default:
      begin
        next_state = S_STANDBY;
      end
    endcase
    if (~chip_active_line_in)
    begin
      next_state = S_STANDBY;
      next_cal_cnt = {CNT_W{1'b0}};
    end
    // Falling select during a receive calibration also starts a new transmit slot.
    else if (rxsel_fall && (state == S_RX_CALIBRATE_PHASE))
    begin
      next_state = S_TX_CALIBRATE_PHASE;
      next_cal_cnt = {CNT_W{1'b0}};
    end
  end

  // ==========================================================================
  // State, edge history and filter tuning register.
  // The edge detectors reset to the idle level of their lines, so no false edge follows reset.
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state <= S_STANDBY;
      cal_cnt <= {CNT_W{1'b0}};
      chip_prev <= 1'b0;
      rxsel_prev <= 1'b0;
      tune <= `TUNE_MID;
    end
    else
    begin
      state <= next_state;
      cal_cnt <= next_cal_cnt;
      chip_prev <= chip_active_line_in;
      rxsel_prev <= receive_select_line_in;
      if (ref_tick_in && (state == S_FULLCAL || state == S_RX_CALIBRATE_PHASE || state == S_TX_CALIBRATE_PHASE))
      begin
        // Simple dither around the stored code stands in for the analog tuning loop.
        tune <= tune + {{(`TUNE_W-1){1'b0}}, cal_cnt[0]} - {{(`TUNE_W-1){1'b0}}, cal_cnt[1]};
      end
    end
  end

  // ==========================================================================
  // Registered outputs, all but filter_tune_out decoded from the next state so they align with it.
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rx_chain_on_out <= 1'b0;
      tx_chain_on_out <= 1'b0;
      tx_rf_output_en_out <= 1'b0;
      synth_loop_close_out <= 1'b1;
      charge_pump_en_out <= 1'b1;
      mod_enable_out <= 1'b0;
      mod_drive_out <= 2'h0;
      lo_shift_out <= 1'b0;
      filter_tune_out <= `TUNE_MID;
      calibrating_out <= 1'b0;
      mode_out <= 5'h01;
      rx_sliced_data_out <= 1'b0;
      tx_data_ready_out <= 1'b0;
    end
    else
    begin
      // every state but standby powers a chain
      rx_chain_on_out <= (next_state == S_RX) || (next_state == S_RX_CALIBRATE_PHASE) || (next_state == S_FULLCAL);
      tx_chain_on_out <= (next_state == S_TX_CALIBRATE_PHASE) || (next_state == S_TX);
      tx_rf_output_en_out <= (next_state == S_TX_CALIBRATE_PHASE) || (next_state == S_TX);
      // loop opens and charge pump stops after transmit calibration
      synth_loop_close_out <= (next_state != S_TX);
      charge_pump_en_out <= (next_state != S_TX) && (next_state != S_STANDBY);
      mod_enable_out <= (next_state == S_TX);
      // bipolar NRZ, 2'b01 for +1 and 2'b11 for -1
      if ((next_state == S_TX) && fifo_out_valid)
      begin
        mod_drive_out <= fifo_out_data ? 2'h1 : 2'h3;
      end
      else
      begin
        mod_drive_out <= 2'h0;
      end
      lo_shift_out <= (next_state == S_TX_CALIBRATE_PHASE) || (next_state == S_TX);
      filter_tune_out <= tune;
      calibrating_out <= (next_state == S_FULLCAL) || (next_state == S_RX_CALIBRATE_PHASE) || (next_state == S_TX_CALIBRATE_PHASE);
      mode_out <= {next_state[5] | next_state[4], next_state[3:0]};
      // sliced NRZ data only in receive
      rx_sliced_data_out <= (next_state == S_RX) ? rx_demod_bit_in : 1'b0;
      tx_data_ready_out <= (next_fill != FIFO_DEPTH[FIFO_AW:0]) && (next_state != S_TX_CALIBRATE_PHASE);
    end
  end

  // ==========================================================================
  // Serial configuration interface, sampled synchronously.
  // Each serial clock level must last at least one clk_in cycle, or a rising edge is missed.
  reg ser_clk_prev;
  reg ser_load_n_prev;
  reg [`CFG_WORD_W-1:0] shift;
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ser_clk_prev <= 1'b0;
      ser_load_n_prev <= 1'b1;
      shift <= {`CFG_WORD_W{1'b0}};
      cfg_reg0_out <= {`CFG_DATA_W{1'b0}};
      cfg_reg1_out <= {`CFG_DATA_W{1'b0}};
      cfg_reg2_out <= {`CFG_DATA_W{1'b0}};
    end
    else
    begin
      ser_clk_prev <= ser_clk_in;
      ser_load_n_prev <= ser_load_n_in;
      // shift on clock rise while strobe low
      if (ser_clk_in && !ser_clk_prev && !ser_load_n_in)
      begin
        // MSB first, address in the last two bits
        shift <= {shift[`CFG_WORD_W-2:0], ser_data_in};
      end
      if (ser_load_n_in && !ser_load_n_prev)
      begin
        case (shift[1:0])
          2'h0: cfg_reg0_out <= shift[`CFG_WORD_W-1:2];
          2'h1: cfg_reg1_out <= shift[`CFG_WORD_W-1:2];
          2'h2: cfg_reg2_out <= shift[`CFG_WORD_W-1:2];
          default: cfg_reg0_out <= cfg_reg0_out;
        endcase
      end
    end
  end
endmodule

// ### fsk_seq_asserts.sv
// Port assertions for the radio mode sequencer.
// Assumes it is bound into the sequencer top: one clock, synchronous reset.
`timescale 1ns/1ps
module fsk_seq_asserts #(
  parameter TX_CALIBRATE_PHASE_CYCLES = 6250
)
(
  // Clock, reset and mode lines
  input wire clk_in,
  input wire rst_in,
  input wire chip_active_line_in,
  input wire receive_select_line_in,
  // Outputs watched
  input wire rx_chain_on_out,
  input wire tx_rf_output_en_out,
  input wire synth_loop_close_out,
  input wire charge_pump_en_out,
  input wire mod_enable_out,
  input wire [1:0] mod_drive_out,
  input wire lo_shift_out,
  input wire [7:0] filter_tune_out,
  input wire calibrating_out,
  input wire [4:0] mode_out
);
  reg [15:0] txc;
  // Cycles spent in transmit calibration; a counter is far cheaper than a long repetition.
  always @(posedge clk_in)
    if (rst_in || !(mode_out[4] && calibrating_out))
      txc <= 16'h0000;
    else
      txc <= txc + 16'h0001;
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_tx_calibrate_phase; mode_out[4] && calibrating_out; endsequence
  sequence s_quiet;
    mod_drive_out == 2'b00 && !mod_enable_out && tx_rf_output_en_out && synth_loop_close_out;
  endsequence
  property p_standby; (!chip_active_line_in) [*3] |-> !rx_chain_on_out && !tx_rf_output_en_out; endproperty
  property p_fullcal; $rose(chip_active_line_in) |-> ##[1:3] mode_out[1] && calibrating_out; endproperty
  property p_tx_calibrate_phase_in;
    mode_out[3] && chip_active_line_in && $fell(receive_select_line_in) |-> ##[1:3] s_tx_calibrate_phase ##0 s_quiet;
  endproperty
  property p_tx_calibrate_phase_hold; s_tx_calibrate_phase |-> s_quiet; endproperty
  property p_tx_calibrate_phase_len; $fell(calibrating_out) && mode_out[4] |-> txc >= TX_CALIBRATE_PHASE_CYCLES - 1 && txc <= TX_CALIBRATE_PHASE_CYCLES + 2;
  endproperty
  property p_tx_open; mode_out[4] && !calibrating_out |-> !synth_loop_close_out && !charge_pump_en_out && mod_enable_out;
  endproperty
  property p_bipolar;
    mod_drive_out != 2'b10 && (mod_drive_out == 2'b00 || (mod_enable_out && mode_out[4] && !calibrating_out));
  endproperty
  property p_lo; mode_out[4] || mode_out[3] |-> lo_shift_out == mode_out[4]; endproperty
  property p_tune; $fell(rst_in) |-> filter_tune_out == 8'h80; endproperty
  a_standby: assert property (p_standby) else $error("chain on in standby");
  a_fullcal: assert property (p_fullcal) else $error("no full calibration");
  a_tx_calibrate_phase_in: assert property (p_tx_calibrate_phase_in) else $error("no tx calibration");
  a_tx_calibrate_phase_hold: assert property (p_tx_calibrate_phase_hold) else $error("tx calibration not quiet");
  a_tx_calibrate_phase_len: assert property (p_tx_calibrate_phase_len) else $error("tx calibration length");
  a_tx_open: assert property (p_tx_open) else $error("tx loop not open");
  a_bipolar: assert property (p_bipolar) else $error("bad symbol");
  a_lo: assert property (p_lo) else $error("lo shift wrong");
  a_tune: assert property (p_tune) else $error("tune not mid");
endmodule
bind fsk_radio_mode_sequencer fsk_seq_asserts #(.TX_CALIBRATE_PHASE_CYCLES(TX_CALIBRATE_PHASE_CYCLES)) i_chk (.clk_in(clk_in),
  .rst_in(rst_in), .chip_active_line_in(chip_active_line_in), .receive_select_line_in(receive_select_line_in),
  .rx_chain_on_out(rx_chain_on_out), .tx_rf_output_en_out(tx_rf_output_en_out),
  .synth_loop_close_out(synth_loop_close_out), .charge_pump_en_out(charge_pump_en_out),
  .mod_enable_out(mod_enable_out), .mod_drive_out(mod_drive_out), .lo_shift_out(lo_shift_out),
  .filter_tune_out(filter_tune_out), .calibrating_out(calibrating_out), .mode_out(mode_out));

// ### fsk_seq_defines.vh
// Constants for the FSK transceiver mode and timing sequencer.
// Assumes a 100 MHz system clock; times are given in their own unit and converted here.
`ifndef FSK_SEQ_DEFINES_VH
`define FSK_SEQ_DEFINES_VH
// ==========================================================================
// Clock and timing
`define CLK_MHZ 100
// Transmit calibration phase, in nanoseconds (62.5 us).
`define TX_CALIBRATE_PHASE_NS 62500
// Complete calibration after chip enable, in nanoseconds (320 us).
`define FULLCAL_NS 320000
// Receive-entry filter calibration, in nanoseconds.
`define RX_CALIBRATE_PHASE_NS 62500
// Longest supported transmit slot, in nanoseconds (10 ms).
`define TX_SLOT_NS 10000000
// Cycle counts derived from the times (least times round up).
`define TX_CALIBRATE_PHASE_CYC ((`TX_CALIBRATE_PHASE_NS * `CLK_MHZ + 999) / 1000)
`define FULLCAL_CYC ((`FULLCAL_NS * `CLK_MHZ + 999) / 1000)
`define RX_CALIBRATE_PHASE_CYC ((`RX_CALIBRATE_PHASE_NS * `CLK_MHZ + 999) / 1000)
`define TX_SLOT_CYC ((`TX_SLOT_NS * `CLK_MHZ) / 1000)
// ==========================================================================
// Filter tuning
`define TUNE_W 8
`define TUNE_MID 8'h80
// Local oscillator offset for the low IF, in kHz (1.024 MHz).
`define LO_SHIFT_KHZ 16'h0400
// ==========================================================================
// Serial configuration word
`define CFG_WORD_W 16
`define CFG_DATA_W 14
`define CFG_ADDR_W 2
`define CFG_NUM_REGS 3
`endif

// ### tb.sv
// Bench for the radio mode sequencer: reset, serial load, slot changes, standby.
// Assumes short calibration counts; the reference ticks every cycle except in one slowed calibration.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t got %h want %h", $time, g, e); end end
module tb;
  localparam TXC = 8, FULC = 32, RXC = 8;
  localparam [19:0] PAT = 20'h9c3a5;
  logic clk_in = 1'b0, rst_in = 1'b1, chip = 1'b0, sel = 1'b1, send = 1'b0;
  logic ser_clk = 1'b0, ser_data = 1'b0, ser_load_n = 1'b1;
  logic tick = 1'b1, slow = 1'b0;
  logic valid, txd, ready, rxd, sliced, rx_on, tx_on, rf_en, loop_close, cp_en, mod_en, lo_shift, cal;
  logic [1:0] drive;
  logic [4:0] sent, mode;
  logic [7:0] tune;
  logic [13:0] cfg0, cfg1, cfg2;
  int mismatches = 0;
  int check_count = 0;
  fsk_radio_mode_sequencer #(.TX_CALIBRATE_PHASE_CYCLES(TXC), .FULLCAL_CYCLES(FULC), .RX_CALIBRATE_PHASE_CYCLES(RXC)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .chip_active_line_in(chip), .receive_select_line_in(sel),
    .ref_tick_in(tick), .tx_data_valid_in(valid), .tx_data_in(txd), .tx_data_ready_out(ready),
    .rx_demod_bit_in(rxd), .rx_sliced_data_out(sliced), .ser_clk_in(ser_clk), .ser_data_in(ser_data),
    .ser_load_n_in(ser_load_n), .cfg_reg0_out(cfg0), .cfg_reg1_out(cfg1), .cfg_reg2_out(cfg2),
    .rx_chain_on_out(rx_on), .tx_chain_on_out(tx_on), .tx_rf_output_en_out(rf_en),
    .synth_loop_close_out(loop_close), .charge_pump_en_out(cp_en), .mod_enable_out(mod_en),
    .mod_drive_out(drive), .lo_shift_out(lo_shift), .filter_tune_out(tune), .calibrating_out(cal), .mode_out(mode));
  bb_model i_bb (.clk_in(clk_in), .rst_in(rst_in), .send_in(send), .pattern_in(PAT), .sent_out(sent),
    .tx_data_valid_out(valid), .tx_data_out(txd), .tx_data_ready_in(ready), .rx_demod_bit_out(rxd));
  // ==========================================================================
  // Clock at 100 MHz.
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end
  // Reference tick: every cycle, or every other cycle while slow is set.
  always @(negedge clk_in)
    tick <= slow ? ~tick : 1'b1;
  // Watchdog; the whole run needs under five hundred cycles.
  initial
  begin
    #40000;
    mismatches++;
    close_out();
  end
  // ==========================================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Waits for a state bit, bounded, and judges how long it took.
  task automatic expect_mode(input int b, input int lo, input int hi);
    int n;
    n = 0;
    while (mode[b] !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
  endtask
  // One word, most significant bit first, on slow serial clock pulses.
  task automatic ser_write(input logic [1:0] a, input logic [13:0] d);
    logic [15:0] w;
    w = {d, a};
    ser_load_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      ser_data = w[i];
      cyc(2);
      ser_clk = 1'b1;
      cyc(2);
      ser_clk = 1'b0;
    end
    ser_load_n = 1'b1;
    cyc(3);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  // Reset state, one load per register, and one to the unused address.
  task automatic t_serial;
    `CHK({mode, tune}, {5'b00001, 8'h80})
    `CHK({rx_on, tx_on, rf_en, loop_close, cp_en}, 5'b00011)
    ser_write(2'h0, 14'h1234);
    ser_write(2'h1, 14'h2bcd);
    ser_write(2'h2, 14'h0f0f);
    ser_write(2'h3, 14'h3fff);
    `CHK({cfg0, cfg1, cfg2}, {14'h1234, 14'h2bcd, 14'h0f0f})
  endtask
  // Enable with receive selected; the buffer then fills until it refuses.
  task automatic t_power;
    chip = 1'b1;
    expect_mode(1, 0, 3);
    cyc(1);
    `CHK({cal, rx_on}, 2'b11)
    expect_mode(3, FULC - 4, FULC + 3);
    `CHK({cal, lo_shift, drive}, 4'b0000)
    send = 1'b1;
    cyc(30);
    `CHK({sent, ready}, {5'd16, 1'b0})
  endtask
  // Receive to transmit: data refused in calibration, then the stored bits as symbols.
  task automatic t_tx;
    int n;
    logic [1:0] q[$];
    sel = 1'b0;
    expect_mode(4, 0, 3);
    `CHK({cal, rf_en, loop_close, mod_en, drive, ready, lo_shift}, 8'he1)
    n = 0;
    while (q.size() < 20 && n < 200)
    begin
      if (drive !== 2'b00)
        q.push_back(drive);
      cyc(1);
      n++;
    end
    for (int i = 0; i < 20; i++)
      `CHK(q[i], PAT[19 - i] ? 2'b01 : 2'b11)
    `CHK({loop_close, cp_en, mod_en, tx_on, cal, sent}, {5'b00110, 5'd20})
  endtask
  // Back to receive through receive calibration.
  task automatic t_rx_back;
    send = 1'b0;
    slow = 1'b1;
    sel = 1'b1;
    expect_mode(2, 0, 3);
    `CHK(cal, 1'b1)
    // Ticks at half rate: the calibration must stretch to twice its tick count.
    expect_mode(3, 2 * RXC - 1, 2 * RXC);
    slow = 1'b0;
    `CHK({lo_shift, mod_en, drive, rx_on}, 5'b00001)
    `CHK(sliced, rxd)
    cyc(1);
    `CHK(sliced, rxd)
  endtask
  // Chip inactive: chains off whatever the select line does, then enable into transmit.
  task automatic t_standby;
    chip = 1'b0;
    cyc(3);
    sel = 1'b0;
    cyc(3);
    `CHK({mode, rx_on, tx_on, rf_en, cp_en, sliced}, 10'b0000100000)
    chip = 1'b1;
    expect_mode(4, FULC, FULC + 8);
  endtask
  // Main sequence: three cycles of reset, then each scenario.
  initial
  begin
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    t_serial();
    t_power();
    t_tx();
    t_rx_back();
    t_standby();
    close_out();
  end
endmodule
